// file: rtl/spx_pkg.sv
// Constants and carrier types of the serial port block
package spx_pkg;

	// Register byte offsets
	localparam logic [7:0] SPX_CTRL_OFS = 8'h00;
	localparam logic [7:0] SPX_STATUS_OFS = 8'h04;
	localparam logic [7:0] SPX_MASK_OFS = 8'h08;
	localparam logic [7:0] SPX_DATA_OFS = 8'h0C;
	localparam logic [7:0] SPX_DIV_OFS = 8'h10;

	// Control field positions
	localparam int SPX_CTRL_PORT_EN_POS = 0;
	localparam int SPX_CTRL_MSEL_LO_POS = 2;
	localparam int SPX_CTRL_MSEL_HI_POS = 3;
	localparam int SPX_CTRL_MASTER_EN_POS = 6;

	// Status and mask bit positions
	localparam int SPX_ST_DONE_POS = 0;
	localparam int SPX_ST_WCOL_POS = 1;
	localparam int SPX_ST_MODE_FAULT_FLAG_POS = 2;
	localparam int SPX_ST_OVR_POS = 3;

	// Reset values and minimum divider
	localparam logic [1:0] SPX_SEL_MODE_RST = 2'h1;
	localparam logic [3:0] SPX_MASK_RST = 4'h0;
	localparam logic [7:0] SPX_DIV_RST = 8'h01;
	localparam logic [7:0] SPX_DIV_MIN = 8'h01;

	// Select mode encodings
	localparam logic [1:0] SPX_SEL_3WIRE = 2'h0;
	localparam logic [1:0] SPX_SEL_4WIRE_IN = 2'h1;

	// Index of the last bit of a byte
	localparam logic [2:0] SPX_LAST_BIT = 3'h7;

	typedef struct packed {
		logic master_en;
		logic [1:0] sel_mode;
		logic port_en;
	} spx_ctrl_t;

	typedef struct packed {
		logic ovr;
		logic mode_fault_flag;
		logic wcol;
		logic done;
	} spx_status_t;

	typedef struct packed {
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
		logic sck_o;
		logic sck_oe;
		logic ss_o;
		logic ss_oe;
		logic ss_routed;
	} spx_pins_t;

	typedef enum logic {
		SPX_IDLE,
		SPX_XFER
	} spx_mstate_t;

endpackage

// file: rtl/spx_port.sv
// Serial port with master and slave modes and an APB register slave
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/10ps

// Notes on behaviour
// - Master drives data-out line, slave reads it
// - Bytes travel most significant bit first
// - Master data-out shows shift register MSB
// - Return line input as master, output slave
// - Return line floats when disabled or deselected
// - Enabled three-line slave always drives return line
// - Master makes serial clock, slave receives it
// - Deselected four-line slave ignores serial clock
// - Mode 00: three-line, slave always selected
// - Mode 01: select input, low selects slave
// - Mode 01 master: select low disables master
// - Mode 1x: select output equals low bit
// - Select pin routed except in mode 00
// - Data write loads buffer, empty shifter starts
// - Mode fault clears enables, sets fault flag
// - Select falling edge resets slave bit counter
// - Master samples return line before falling edge
module spx_port (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe,
	input wire logic ss_i,
	output logic ss_o,
	output logic ss_oe,
	output logic ss_routed,
	output logic irq
);

	// Synchroniser lanes: 0 sck, 1 mosi, 2 miso, 3 select
	logic [3:0] sync1_ff, sync2_ff, prev_ff;

	spx_pkg::spx_ctrl_t ctrl_ff, nxt_ctrl;
	spx_pkg::spx_status_t status_ff, nxt_status;
	logic [3:0] mask_ff, nxt_mask;
	logic [7:0] div_ff, nxt_div;
	logic [7:0] tx_buf_ff, nxt_tx_buf;
	logic tx_full_ff, nxt_tx_full;
	logic [7:0] rx_buf_ff, nxt_rx_buf;
	logic rx_full_ff, nxt_rx_full;
	logic [7:0] shift_ff, nxt_shift;
	logic shift_full_ff, nxt_shift_full;
	logic [2:0] bits_ff, nxt_bits;
	logic rx_bit_ff, nxt_rx_bit;
	logic [7:0] cnt_ff, nxt_cnt;
	logic sck_ff, nxt_sck;
	spx_pkg::spx_mstate_t mstate_ff, nxt_mstate;
	spx_pkg::spx_pins_t pins_ff, nxt_pins;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic irq_ff, nxt_irq;

	logic sck_s, mosi_s, miso_s, ss_s;
	logic sck_rise, sck_fall, ss_fall;
	logic acc_done, wr, rd, mapped;
	logic is_master, selected, byte_done;
	logic [3:0] st_set, st_clr;
	logic [31:0] rdata;

	assign sck_s = sync2_ff[0];
	assign mosi_s = sync2_ff[1];
	assign miso_s = sync2_ff[2];
	assign ss_s = sync2_ff[3];
	assign sck_rise = sync2_ff[0] & ~prev_ff[0];
	assign sck_fall = ~sync2_ff[0] & prev_ff[0];
	assign ss_fall = ~sync2_ff[3] & prev_ff[3];

	assign acc_done = psel & penable & pready_ff;
	assign wr = acc_done & pwrite;
	assign rd = acc_done & ~pwrite;
	assign is_master = ctrl_ff.master_en;

	always_comb begin
		mapped = 1'b1;
		rdata = 32'h0000_0000;
		case (paddr)
			spx_pkg::SPX_CTRL_OFS: begin
				rdata[spx_pkg::SPX_CTRL_PORT_EN_POS] = ctrl_ff.port_en;
				rdata[spx_pkg::SPX_CTRL_MSEL_LO_POS] = ctrl_ff.sel_mode[0];
				rdata[spx_pkg::SPX_CTRL_MSEL_HI_POS] = ctrl_ff.sel_mode[1];
				rdata[spx_pkg::SPX_CTRL_MASTER_EN_POS] = ctrl_ff.master_en;
			end
			spx_pkg::SPX_STATUS_OFS: begin
				rdata[3:0] = status_ff;
			end
			spx_pkg::SPX_MASK_OFS: begin
				rdata[3:0] = mask_ff;
			end
			spx_pkg::SPX_DATA_OFS: begin
				rdata[7:0] = rx_buf_ff;
			end
			spx_pkg::SPX_DIV_OFS: begin
				rdata[7:0] = div_ff;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// Slave selection per select mode
	always_comb begin
		case (ctrl_ff.sel_mode)
			spx_pkg::SPX_SEL_3WIRE: selected = 1'b1;
			spx_pkg::SPX_SEL_4WIRE_IN: selected = ~ss_s;
			default: selected = 1'b1;
		endcase
	end

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_mask = mask_ff;
		nxt_div = div_ff;
		nxt_tx_buf = tx_buf_ff;
		nxt_tx_full = tx_full_ff;
		nxt_rx_buf = rx_buf_ff;
		nxt_rx_full = rx_full_ff;
		nxt_shift = shift_ff;
		nxt_shift_full = shift_full_ff;
		nxt_bits = bits_ff;
		nxt_rx_bit = rx_bit_ff;
		nxt_cnt = cnt_ff;
		nxt_sck = sck_ff;
		nxt_mstate = mstate_ff;
		byte_done = 1'b0;
		st_set = 4'h0;
		st_clr = 4'h0;

		nxt_pready = psel & penable & ~pready_ff;
		nxt_prdata = prdata_ff;
		nxt_pslverr = 1'b0;
		if (psel & penable & ~pready_ff) begin
			nxt_prdata = pwrite ? 32'h0000_0000 : rdata;
			nxt_pslverr = ~mapped;
		end

		if (wr) begin
			case (paddr)
				spx_pkg::SPX_CTRL_OFS: begin
					nxt_ctrl.port_en = pwdata[spx_pkg::SPX_CTRL_PORT_EN_POS];
					nxt_ctrl.sel_mode = {pwdata[spx_pkg::SPX_CTRL_MSEL_HI_POS],
						pwdata[spx_pkg::SPX_CTRL_MSEL_LO_POS]};
					nxt_ctrl.master_en = pwdata[spx_pkg::SPX_CTRL_MASTER_EN_POS];
				end
				spx_pkg::SPX_STATUS_OFS: st_clr = pwdata[3:0];
				spx_pkg::SPX_MASK_OFS: nxt_mask = pwdata[3:0];
				spx_pkg::SPX_DIV_OFS: begin
					nxt_div = (pwdata[7:0] < spx_pkg::SPX_DIV_MIN) ?
						spx_pkg::SPX_DIV_MIN : pwdata[7:0];
				end
				spx_pkg::SPX_DATA_OFS: begin
					if (tx_full_ff) begin
						st_set[spx_pkg::SPX_ST_WCOL_POS] = 1'b1;
					end else begin
						nxt_tx_buf = pwdata[7:0];
						nxt_tx_full = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (rd && paddr == spx_pkg::SPX_DATA_OFS) begin
			nxt_rx_full = 1'b0;
		end

		if (!ctrl_ff.port_en) begin
			nxt_shift_full = 1'b0;
			nxt_bits = 3'h0;
			nxt_cnt = 8'h00;
			nxt_sck = 1'b0;
			nxt_mstate = spx_pkg::SPX_IDLE;
		end else if (is_master) begin
			// Another master pulled the select line down
			if (ctrl_ff.sel_mode == spx_pkg::SPX_SEL_4WIRE_IN && !ss_s) begin
				nxt_ctrl.master_en = 1'b0;
				nxt_ctrl.port_en = 1'b0;
				st_set[spx_pkg::SPX_ST_MODE_FAULT_FLAG_POS] = 1'b1;
				nxt_shift_full = 1'b0;
				nxt_bits = 3'h0;
				nxt_cnt = 8'h00;
				nxt_sck = 1'b0;
				nxt_mstate = spx_pkg::SPX_IDLE;
			end else begin
				case (mstate_ff)
					spx_pkg::SPX_IDLE: begin
						if (tx_full_ff && !shift_full_ff) begin
							nxt_shift = tx_buf_ff;
							nxt_tx_full = 1'b0;
							nxt_shift_full = 1'b1;
							nxt_bits = 3'h0;
							nxt_cnt = 8'h00;
							nxt_mstate = spx_pkg::SPX_XFER;
						end
					end
					spx_pkg::SPX_XFER: begin
						if (cnt_ff == div_ff - 8'h01 && sck_ff) begin
							nxt_rx_bit = miso_s;
						end
						if (cnt_ff == div_ff) begin
							nxt_cnt = 8'h00;
							nxt_sck = ~sck_ff;
							if (sck_ff) begin
								nxt_shift = {shift_ff[6:0], rx_bit_ff};
								nxt_bits = bits_ff + 3'h1;
								if (bits_ff == spx_pkg::SPX_LAST_BIT) begin
									byte_done = 1'b1;
									nxt_mstate = spx_pkg::SPX_IDLE;
								end
							end
						end else begin
							nxt_cnt = cnt_ff + 8'h01;
						end
					end
					default: nxt_mstate = spx_pkg::SPX_IDLE;
				endcase
			end
		end else begin
			nxt_mstate = spx_pkg::SPX_IDLE;
			nxt_sck = 1'b0;
			if (tx_full_ff && !shift_full_ff) begin
				nxt_shift = tx_buf_ff;
				nxt_tx_full = 1'b0;
				nxt_shift_full = 1'b1;
			end
			if (ctrl_ff.sel_mode == spx_pkg::SPX_SEL_4WIRE_IN && ss_fall) begin
				nxt_bits = 3'h0;
			end else if (selected) begin
				if (sck_rise) begin
					nxt_rx_bit = mosi_s;
				end
				if (sck_fall) begin
					nxt_shift = {shift_ff[6:0], rx_bit_ff};
					nxt_bits = bits_ff + 3'h1;
					if (bits_ff == spx_pkg::SPX_LAST_BIT) begin
						byte_done = 1'b1;
					end
				end
			end
		end

		if (byte_done) begin
			nxt_shift_full = 1'b0;
			st_set[spx_pkg::SPX_ST_DONE_POS] = 1'b1;
			if (rx_full_ff && !is_master && !nxt_rx_full) begin
				nxt_rx_buf = nxt_shift;
				nxt_rx_full = 1'b1;
			end else if (rx_full_ff && !is_master) begin
				st_set[spx_pkg::SPX_ST_OVR_POS] = 1'b1;
			end else begin
				nxt_rx_buf = nxt_shift;
				nxt_rx_full = 1'b1;
			end
		end

		// Hardware set wins over a same-cycle software clear
		nxt_status = (status_ff & ~st_clr) | st_set;
		nxt_irq = |(nxt_status & nxt_mask);

		// Pin drive, registered so every pin comes from a flop
		nxt_pins.mosi_o = nxt_shift[7];
		nxt_pins.mosi_oe = nxt_ctrl.port_en & nxt_ctrl.master_en;
		nxt_pins.miso_o = nxt_shift[7];
		nxt_pins.miso_oe = nxt_ctrl.port_en & ~nxt_ctrl.master_en &
			selected;
		nxt_pins.sck_o = nxt_sck;
		nxt_pins.sck_oe = nxt_ctrl.port_en & nxt_ctrl.master_en;
		nxt_pins.ss_o = nxt_ctrl.sel_mode[0];
		nxt_pins.ss_oe = nxt_ctrl.sel_mode[1];
		nxt_pins.ss_routed = (nxt_ctrl.sel_mode != spx_pkg::SPX_SEL_3WIRE);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_ff <= 4'h8;
			sync2_ff <= 4'h8;
			prev_ff <= 4'h8;
		end else begin
			sync1_ff <= {ss_i, miso_i, mosi_i, sck_i};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= '{master_en: 1'b0, sel_mode: spx_pkg::SPX_SEL_MODE_RST,
				port_en: 1'b0};
			status_ff <= 4'h0;
			mask_ff <= spx_pkg::SPX_MASK_RST;
			div_ff <= spx_pkg::SPX_DIV_RST;
			tx_buf_ff <= 8'h00;
			tx_full_ff <= 1'b0;
			rx_buf_ff <= 8'h00;
			rx_full_ff <= 1'b0;
			shift_ff <= 8'h00;
			shift_full_ff <= 1'b0;
			bits_ff <= 3'h0;
			rx_bit_ff <= 1'b0;
			cnt_ff <= 8'h00;
			sck_ff <= 1'b0;
			mstate_ff <= spx_pkg::SPX_IDLE;
			pins_ff <= '{ss_o: 1'b1, ss_routed: 1'b1, default: 1'b0};
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			div_ff <= nxt_div;
			tx_buf_ff <= nxt_tx_buf;
			tx_full_ff <= nxt_tx_full;
			rx_buf_ff <= nxt_rx_buf;
			rx_full_ff <= nxt_rx_full;
			shift_ff <= nxt_shift;
			shift_full_ff <= nxt_shift_full;
			bits_ff <= nxt_bits;
			rx_bit_ff <= nxt_rx_bit;
			cnt_ff <= nxt_cnt;
			sck_ff <= nxt_sck;
			mstate_ff <= nxt_mstate;
			pins_ff <= nxt_pins;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			irq_ff <= nxt_irq;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign mosi_o = pins_ff.mosi_o;
	assign mosi_oe = pins_ff.mosi_oe;
	assign miso_o = pins_ff.miso_o;
	assign miso_oe = pins_ff.miso_oe;
	assign sck_o = pins_ff.sck_o;
	assign sck_oe = pins_ff.sck_oe;
	assign ss_o = pins_ff.ss_o;
	assign ss_oe = pins_ff.ss_oe;
	assign ss_routed = pins_ff.ss_routed;
	assign irq = irq_ff;

endmodule

// file: verification/spx_far.sv
// Behavioural far-side serial slave
`timescale 1ns/10ps
module spx_far (
	input wire logic sck,
	input wire logic mosi,
	input wire logic ss_n,
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	logic [7:0] sh = 8'h00;
	initial rx = 8'h00;
	// Sole slave, loaded when selected
	always @(negedge ss_n) sh <= tx;
	always @(posedge sck) if (!ss_n) rx <= {rx[6:0], mosi};
	always @(negedge sck) if (!ss_n) sh <= {sh[6:0], 1'b0};
	// Released line shows inverse of last bit
	assign miso = ss_n ? ~sh[7] : sh[7];
endmodule

// file: verification/spx_port_assertions.sv
// Concurrent checks on the serial port pins and bus
`timescale 1ns/10ps
module spx_port_chk (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic mosi_i,
	input wire logic mosi_o,
	input wire logic mosi_oe,
	input wire logic miso_i,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic sck_i,
	input wire logic sck_o,
	input wire logic sck_oe,
	input wire logic ss_i,
	input wire logic ss_o,
	input wire logic ss_oe,
	input wire logic ss_routed,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence answer_s;
		penable && !pready ##1 pready;
	endsequence
	sequence fault_s;
		mosi_oe && ss_routed && !ss_oe && !ss_i;
	endsequence
	sequence deselect_s;
		(ss_routed && !ss_oe && ss_i) [*5];
	endsequence
	apb_wait_a: assert property (setup_s |=> answer_s)
		else $error("bus wait state wrong");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	sck_drive_a: assert property ($rose(sck_o) |-> sck_oe && mosi_oe)
		else $error("clock toggles undriven");
	miso_master_a: assert property (mosi_oe |-> !miso_oe)
		else $error("return line driven as master");
	ss_route_a: assert property (ss_oe |-> ss_routed)
		else $error("select driven but unrouted");
	mode_fault_a: assert property (fault_s |-> ##[1:6] !mosi_oe)
		else $error("master kept after select low");
	miso_float_a: assert property (deselect_s |-> !miso_oe)
		else $error("return line driven deselected");
endmodule
bind spx_port spx_port_chk chk (.clk(clk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .mosi_i(mosi_i),
	.mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o),
	.miso_oe(miso_oe), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe),
	.ss_i(ss_i), .ss_o(ss_o), .ss_oe(ss_oe), .ss_routed(ss_routed), .irq(irq));

// file: verification/spx_port_tb.sv
// Self-checking bench of the serial port block
`timescale 1ns/10ps
module spx_port_tb;
	logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, mosi_i = 1'b0, sck_i = 1'b0, ss_i = 1'b1, err;
	logic [7:0] paddr = 8'h00, ptx = 8'h00, prx;
	logic [31:0] pwdata = 32'h0, prdata, rnd = 32'hA71102F9;
	logic pready, pslverr, irq, mosi_o, mosi_oe, miso_o, miso_oe;
	logic sck_o, sck_oe, ss_o, ss_oe, ss_routed, pmiso;
	logic [1:0] md;
	logic [7:0] smiso = 8'h00;
	logic [31:0] expq[$];
	int error_cnt = 0, checked = 0;
	always #12.5 clk = ~clk;
	spx_port DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mosi_i(mosi_i), .mosi_o(mosi_o),
		.mosi_oe(mosi_oe), .miso_i(pmiso), .miso_o(miso_o), .miso_oe(miso_oe),
		.sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .ss_i(ss_i),
		.ss_o(ss_o), .ss_oe(ss_oe), .ss_routed(ss_routed), .irq(irq));
	spx_far far (.sck(sck_oe & sck_o), .mosi(mosi_o), .ss_n(!ss_oe | ss_o),
		.tx(ptx), .miso(pmiso), .rx(prx));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task conclude;
		if (error_cnt == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			conclude();
		end
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task await_irq(input logic v);
		int n;
		for (n = 0; n < 2000 && irq !== v; n++)
			@(posedge clk);
		if (irq !== v) begin
			error_cnt++;
			conclude();
		end
	endtask
	// Slave byte at the link clock rate, data changes while clock low
	task sbyte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			mosi_i <= v[i];
			repeat (4) @(posedge clk);
			smiso = {smiso[6:0], miso_o};
			sck_i <= 1'b1;
			repeat (4) @(posedge clk);
			sck_i <= 1'b0;
		end
	endtask
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk("prdata", prdata, expq.pop_front());
	end
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		rd(8'h00, 32'h4);
		chk("ss_routed", ss_routed, 1'b1);
		chk("miso_oe", miso_oe, 1'b0);
		rd(8'h14, 32'h0);
		chk("pslverr", err, 1'b1);
		for (int m = 0; m < 4; m++) begin
			md = m[1:0];
			apb(1'b1, 8'h00, 32'h41 | (m << 2));
			repeat (3) @(posedge clk);
			chk("mosi_oe", mosi_oe, 1'b1);
			chk("sck_oe", sck_oe, 1'b1);
			chk("miso_oe", miso_oe, 1'b0);
			chk("ss_oe", ss_oe, md[1]);
			if (md[1]) chk("ss_o", ss_o, md[0]);
			chk("ss_routed", ss_routed, md != 2'h0);
		end
		rnd = lfsr(rnd);
		ptx <= rnd[15:8];
		apb(1'b1, 8'h10, {30'h0, rnd[17:16]});
		apb(1'b1, 8'h00, 32'h49);
		apb(1'b1, 8'h08, 32'h1);
		apb(1'b1, 8'h0C, {24'h0, rnd[7:0]});
		await_irq(1'b1);
		chk("far rx", prx, rnd[7:0]);
		rd(8'h0C, {24'h0, rnd[15:8]});
		apb(1'b1, 8'h08, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq", irq, 1'b0);
		apb(1'b1, 8'h08, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq", irq, 1'b1);
		apb(1'b1, 8'h04, 32'h1);
		await_irq(1'b0);
		apb(1'b1, 8'h00, 32'h45);
		ss_i <= 1'b0;
		repeat (6) @(posedge clk);
		chk("mosi_oe", mosi_oe, 1'b0);
		rd(8'h04, 32'h4);
		rd(8'h00, 32'h4);
		apb(1'b1, 8'h04, 32'h4);
		ss_i <= 1'b1;
		apb(1'b1, 8'h00, 32'h01);
		repeat (3) @(posedge clk);
		chk("miso_oe", miso_oe, 1'b1);
		chk("mosi_oe", mosi_oe, 1'b0);
		apb(1'b1, 8'h00, 32'h05);
		repeat (5) @(posedge clk);
		chk("miso_oe", miso_oe, 1'b0);
		sbyte(8'hA5);
		ss_i <= 1'b0;
		repeat (6) @(posedge clk);
		chk("miso_oe", miso_oe, 1'b1);
		rnd = lfsr(rnd);
		apb(1'b1, 8'h0C, {24'h0, rnd[31:24]});
		apb(1'b1, 8'h0C, {24'h0, rnd[23:16]});
		apb(1'b1, 8'h0C, 32'h0);
		rd(8'h04, 32'h2);
		apb(1'b1, 8'h04, 32'h2);
		chk("miso_o", miso_o, rnd[31]);
		sbyte(rnd[7:0]);
		chk("miso bits", smiso, rnd[31:24]);
		repeat (6) @(posedge clk);
		sbyte(rnd[15:8]);
		chk("miso bits", smiso, rnd[23:16]);
		repeat (6) @(posedge clk);
		rd(8'h04, 32'h9);
		rd(8'h0C, {24'h0, rnd[7:0]});
		ss_i <= 1'b1;
		@(posedge clk);
		conclude();
	end
endmodule
